/* verilog/ccr_top.sv */
/*
 * Core control register: clear-only priority status flag, program space window enable,
 * full priority level output and the data space window that the window enable controls.
 * Assumes core logic on ref_clk drives the register port, the low priority bits,
 * the priority raise pulse and data space reads; nothing here crosses a clock.
 */
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "ccr_defines.svh"

// How it works
// - bits 15..4 and 1..0 read zero; writes to them are ignored.
// - bit 3 reads one when priority level exceeds 7, else zero.
// - program memory appears in data space window only while bit 2 is set.
// - full level is bit 3 above the three cpu_priority_low_bits input bits.
module ccr_top
	import ccr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire ccr_addr_t reg_addr,
	input wire ccr_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output ccr_word_t reg_rdata_q,
	input wire ccr_low_t cpu_priority_low_bits,
	input wire logic cpu_priority_raise,
	output logic cpu_priority_msb_flag_q,
	output ccr_level_t cpu_priority_level_q,
	output logic program_space_window_enable_q,
	input wire logic ds_rd,
	input wire ccr_word_t ds_addr,
	input wire ccr_page_t window_page,
	output logic pm_rd_q,
	output ccr_pm_addr_t pm_addr_q
);

	// ****************************************
	// address decode
	// ****************************************
	function automatic logic ccr_hit(input ccr_addr_t addr);
		ccr_hit = (addr == `CCR_CORE_CONTROL_ADDR);
	endfunction

	logic wr_hit;
	logic rd_hit;
	logic prio_flag_d;
	logic win_en_d;
	ccr_level_t level_d;
	ccr_word_t rdata_d;
	ccr_word_t reg_view;

	assign wr_hit = reg_wr && ccr_hit(reg_addr);
	assign rd_hit = reg_rd && ccr_hit(reg_addr);

	// ****************************************
	// register state
	// ****************************************
	always_comb begin
		prio_flag_d = cpu_priority_msb_flag_q;
		win_en_d = program_space_window_enable_q;
		if (wr_hit) begin
			win_en_d = reg_wdata[`CCR_WIN_EN_BIT];
			// writing zero clears, writing one has no effect
			if (!reg_wdata[`CCR_PRIO_FLAG_BIT]) begin
				prio_flag_d = 1'b0;
			end
		end
		// hardware raise wins over a clear in the same cycle
		if (cpu_priority_raise) begin
			prio_flag_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cpu_priority_msb_flag_q <= `CCR_PRIO_FLAG_RESET;
			program_space_window_enable_q <= `CCR_WIN_EN_RESET;
		end else begin
			cpu_priority_msb_flag_q <= prio_flag_d;
			program_space_window_enable_q <= win_en_d;
		end
	end

	// ****************************************
	// priority level
	// ****************************************
	always_comb begin
		level_d = {prio_flag_d, cpu_priority_low_bits};
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cpu_priority_level_q <= `CCR_LEVEL_RESET;
		end else begin
			cpu_priority_level_q <= level_d;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		reg_view = `CCR_READ_IDLE;
		reg_view[`CCR_PRIO_FLAG_BIT] = cpu_priority_msb_flag_q;
		reg_view[`CCR_WIN_EN_BIT] = program_space_window_enable_q;
		rdata_d = `CCR_READ_IDLE;
		if (rd_hit) begin
			rdata_d = reg_view;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= `CCR_READ_IDLE;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// program space window
	// ****************************************
	ccr_window u_window (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.program_space_window_enable(program_space_window_enable_q),
		.ds_rd(ds_rd),
		.ds_addr(ds_addr),
		.window_page(window_page),
		.pm_rd_q(pm_rd_q),
		.pm_addr_q(pm_addr_q)
	);

	// ****************************************
	// checks
	// ****************************************
	chk_unimpl_read_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
		reg_rd |=> (reg_rdata_q[15:4] == 12'h000 && reg_rdata_q[1:0] == 2'h0))
		else $error("unimplemented bits read non-zero");

	chk_level_status: assert property (@(posedge ref_clk) disable iff (!resetn)
		##1 (cpu_priority_msb_flag_q == (cpu_priority_level_q > `CCR_LEVEL_LIMIT)))
		else $error("priority flag disagrees with level");

	chk_read_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
		rd_hit |=> (reg_rdata_q[3] == $past(cpu_priority_msb_flag_q)
			&& reg_rdata_q[2] == $past(program_space_window_enable_q)))
		else $error("read data does not show register state");

	chk_level_concat: assert property (@(posedge ref_clk) disable iff (!resetn)
		resetn |=> (cpu_priority_level_q[2:0] == $past(cpu_priority_low_bits)))
		else $error("low priority bits not carried into level");

	chk_no_sw_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit && !cpu_priority_msb_flag_q && !cpu_priority_raise) |=> !cpu_priority_msb_flag_q)
		else $error("software write set priority flag");

	chk_sw_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit && !reg_wdata[3] && !cpu_priority_raise) |=> !cpu_priority_msb_flag_q)
		else $error("software clear of priority flag lost");

	chk_raise_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
		cpu_priority_raise |=> cpu_priority_msb_flag_q)
		else $error("priority raise lost");

	chk_enable_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		wr_hit |=> (program_space_window_enable_q == $past(reg_wdata[2])))
		else $error("window enable not written");

	chk_enable_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!wr_hit |=> $stable(program_space_window_enable_q))
		else $error("window enable changed without a write");

	chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reg_rd && !ccr_hit(reg_addr)) |=> (reg_rdata_q == `CCR_READ_IDLE))
		else $error("unmapped read returned data");

	chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		!reg_rd |=> (reg_rdata_q == `CCR_READ_IDLE))
		else $error("read data shown without a read");

	chk_unmapped_wr_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reg_wr && !ccr_hit(reg_addr) && !cpu_priority_raise) |=> $stable(cpu_priority_msb_flag_q))
		else $error("unmapped write changed priority flag");

	chk_unmapped_wr_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reg_wr && !ccr_hit(reg_addr)) |=> $stable(program_space_window_enable_q))
		else $error("unmapped write changed window enable");

	chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!wr_hit && !cpu_priority_raise) |=> $stable(cpu_priority_msb_flag_q))
		else $error("priority flag changed without cause");

	chk_level_raise: assert property (@(posedge ref_clk) disable iff (!resetn)
		cpu_priority_raise |=> (cpu_priority_level_q > `CCR_LEVEL_LIMIT))
		else $error("raised level not above seven");

	chk_level_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit && !reg_wdata[`CCR_PRIO_FLAG_BIT] && !cpu_priority_raise)
		|=> (cpu_priority_level_q <= `CCR_LEVEL_LIMIT))
		else $error("cleared level above seven");

	chk_raise_level_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		cpu_priority_raise |=> (cpu_priority_level_q == {1'b1, $past(cpu_priority_low_bits)}))
		else $error("raised level not formed from flag and low bits");

	chk_read_after_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit ##1 rd_hit) |=> (reg_rdata_q[`CCR_WIN_EN_BIT] == $past(reg_wdata[`CCR_WIN_EN_BIT], 2)))
		else $error("read after write does not show new enable");

	chk_enable_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit && reg_wdata[`CCR_WIN_EN_BIT]) |=> program_space_window_enable_q)
		else $error("window enable not set by write");

	chk_enable_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_hit && !reg_wdata[`CCR_WIN_EN_BIT]) |=> !program_space_window_enable_q)
		else $error("window enable not cleared by write");

	chk_pm_read_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
		pm_rd_q |-> $past(program_space_window_enable_q))
		else $error("program read without window enable");

endmodule

/* verilog/ccr_defines.svh */
/*
 * Offsets, bit positions, reset values and window decode for the core control register.
 * Assumes inclusion by its bare name from the design modules and the bench.
 */
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define CCR_CORE_CONTROL_ADDR 8'h00
`define CCR_CORE_CONTROL_RESET 16'h0000
`define CCR_PRIO_FLAG_RESET 1'b0
`define CCR_WIN_EN_RESET 1'b0
`define CCR_READ_IDLE 16'h0000

// ****************************************
// field positions
// ****************************************
`define CCR_PRIO_FLAG_BIT 3
`define CCR_WIN_EN_BIT 2

// ****************************************
// priority level
// ****************************************
`define CCR_LEVEL_LIMIT 4'h7
`define CCR_LEVEL_RESET 4'h0

// ****************************************
// program space window in data space
// ****************************************
`define CCR_WIN_SEL_BIT 15
`define CCR_PM_ADDR_RESET 24'h000000

`endif

/* verilog/ccr_pkg.sv */
/*
 * Types shared by the core control register and its data space window.
 * Assumes ccr_defines.svh is on the include path.
 */
package ccr_pkg;
	typedef logic [15:0] ccr_word_t;
	typedef logic [7:0] ccr_addr_t;
	typedef logic [3:0] ccr_level_t;
	typedef logic [2:0] ccr_low_t;
	typedef logic [7:0] ccr_page_t;
	typedef logic [23:0] ccr_pm_addr_t;
endpackage

/* verilog/ccr_window.sv */
/*
 * Program space window: maps upper data space reads onto program memory while enabled.
 * Assumes data space requests come from logic on ref_clk; the page comes from the core.
 */
`timescale 1ns/100ps
`include "ccr_defines.svh"

module ccr_window
	import ccr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic program_space_window_enable,
	input wire logic ds_rd,
	input wire ccr_word_t ds_addr,
	input wire ccr_page_t window_page,
	output logic pm_rd_q,
	output ccr_pm_addr_t pm_addr_q
);

	logic pm_rd_d;
	ccr_pm_addr_t pm_addr_d;

	// ****************************************
	// window decode
	// ****************************************
	always_comb begin
		pm_rd_d = ds_rd && ds_addr[`CCR_WIN_SEL_BIT] && program_space_window_enable;
		pm_addr_d = pm_addr_q;
		if (pm_rd_d) begin
			pm_addr_d = {window_page, 1'b0, ds_addr[14:0]};
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pm_rd_q <= 1'b0;
			pm_addr_q <= `CCR_PM_ADDR_RESET;
		end else begin
			pm_rd_q <= pm_rd_d;
			pm_addr_q <= pm_addr_d;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_window_closed: assert property (@(posedge ref_clk) disable iff (!resetn)
		(ds_rd && !program_space_window_enable) |=> !pm_rd_q)
		else $error("program read while window disabled");

	chk_window_open: assert property (@(posedge ref_clk) disable iff (!resetn)
		(ds_rd && program_space_window_enable && ds_addr[`CCR_WIN_SEL_BIT])
		|=> (pm_rd_q && pm_addr_q[14:0] == $past(ds_addr[14:0]) && pm_addr_q[23:16] == $past(window_page)))
		else $error("window read not mapped to program memory");

endmodule

/* sim/ccr_top_tb.sv */
/*
 * Self-checking bench for the core control register and its data space window.
 * Assumes ccr_pkg is compiled first and ccr_defines.svh is on the include path.
 */
`timescale 1ns/100ps
`include "ccr_defines.svh"

module ccr_top_tb
	import ccr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	ccr_addr_t reg_addr = 8'h00;
	ccr_word_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	ccr_word_t reg_rdata_q;
	ccr_low_t cpu_priority_low_bits = 3'h0;
	logic cpu_priority_raise = 1'b0;
	logic cpu_priority_msb_flag_q;
	ccr_level_t cpu_priority_level_q;
	logic program_space_window_enable_q;
	logic ds_rd = 1'b0;
	ccr_word_t ds_addr = 16'h0000;
	ccr_page_t window_page = 8'h00;
	logic pm_rd_q;
	ccr_pm_addr_t pm_addr_q;
	int errors = 0;
	int samples_checked = 0;
	ccr_word_t v;

	ccr_top dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.cpu_priority_low_bits(cpu_priority_low_bits), .cpu_priority_raise(cpu_priority_raise),
		.cpu_priority_msb_flag_q(cpu_priority_msb_flag_q), .cpu_priority_level_q(cpu_priority_level_q),
		.program_space_window_enable_q(program_space_window_enable_q), .ds_rd(ds_rd), .ds_addr(ds_addr),
		.window_page(window_page), .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q));

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task chk(input string n, input logic [23:0] e, input logic [23:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task wr(input ccr_addr_t a, input ccr_word_t d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input ccr_addr_t a, output ccr_word_t d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask

	task ds(input ccr_word_t a, input ccr_page_t p, input logic e);
		@(posedge ref_clk);
		ds_rd <= 1'b1;
		ds_addr <= a;
		window_page <= p;
		@(posedge ref_clk);
		ds_rd <= 1'b0;
		#1 chk("pm_rd_q", {23'h0, e}, {23'h0, pm_rd_q});
		if (e) chk("pm_addr_q", {p, 1'b0, a[14:0]}, pm_addr_q);
	endtask

	task end_sim;
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		rd(`CCR_CORE_CONTROL_ADDR, v);
		chk("core_control reset", 24'h0, {8'h0, v});
	endtask

	task t_reg;
		wr(`CCR_CORE_CONTROL_ADDR, 16'hFFFF);
		rd(`CCR_CORE_CONTROL_ADDR, v);
		chk("core_control ones", 24'h0004, {8'h0, v});
		@(posedge ref_clk);
		#1 chk("rdata idle", 24'h0, {8'h0, reg_rdata_q});
		wr(8'h04, 16'h0000);
		rd(8'h04, v);
		chk("unmapped read", 24'h0, {8'h0, v});
		chk("enable kept", 24'h1, {23'h0, program_space_window_enable_q});
	endtask

	task t_prio;
		@(posedge ref_clk);
		cpu_priority_raise <= 1'b1;
		cpu_priority_low_bits <= 3'h5;
		@(posedge ref_clk);
		cpu_priority_raise <= 1'b0;
		#1 chk("level raised", 24'hD, {20'h0, cpu_priority_level_q});
		chk("flag raised", 24'h1, {23'h0, cpu_priority_msb_flag_q});
		rd(`CCR_CORE_CONTROL_ADDR, v);
		chk("flag read", 24'h000C, {8'h0, v});
		wr(`CCR_CORE_CONTROL_ADDR, 16'h0004);
		#1 chk("flag cleared", 24'h5, {20'h0, cpu_priority_level_q});
		wr(`CCR_CORE_CONTROL_ADDR, 16'h000C);
		rd(`CCR_CORE_CONTROL_ADDR, v);
		chk("flag not set", 24'h0004, {8'h0, v});
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= `CCR_CORE_CONTROL_ADDR;
		reg_wdata <= 16'h0004;
		cpu_priority_raise <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		cpu_priority_raise <= 1'b0;
		#1 chk("raise over clear", 24'h1, {23'h0, cpu_priority_msb_flag_q});
		wr(`CCR_CORE_CONTROL_ADDR, 16'h0004);
		#1 chk("flag cleared again", 24'h0, {23'h0, cpu_priority_msb_flag_q});
	endtask

	task t_window;
		ds(16'h8010, 8'h02, 1'b1);
		ds(16'hFFFE, 8'h7F, 1'b1);
		ds(16'h0010, 8'h02, 1'b0);
		wr(`CCR_CORE_CONTROL_ADDR, 16'h0000);
		ds(16'h8010, 8'h02, 1'b0);
		chk("addr held", 24'h7F7FFE, pm_addr_q);
	endtask

	task t_b2b;
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= `CCR_CORE_CONTROL_ADDR;
		reg_wdata <= 16'h0004;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("read after write", 24'h0004, {8'h0, reg_rdata_q});
	endtask

	task t_mid_reset;
		@(posedge ref_clk);
		cpu_priority_raise <= 1'b1;
		@(posedge ref_clk);
		cpu_priority_raise <= 1'b0;
		#1 chk("flag before reset", 24'h1, {23'h0, cpu_priority_msb_flag_q});
		@(posedge ref_clk);
		resetn <= 1'b0;
		@(posedge ref_clk);
		#1 chk("flag in reset", 24'h0, {23'h0, cpu_priority_msb_flag_q});
		chk("enable in reset", 24'h0, {23'h0, program_space_window_enable_q});
		chk("level in reset", 24'h0, {20'h0, cpu_priority_level_q});
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(`CCR_CORE_CONTROL_ADDR, v);
		chk("core_control after reset", 24'h0, {8'h0, v});
		chk("level after reset", 24'h5, {20'h0, cpu_priority_level_q});
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_reg();
		t_prio();
		t_window();
		t_b2b();
		t_mid_reset();
		end_sim();
	end
endmodule
